// ===== adc_ctl_pkg.sv
// Register map, field layout and timing constants of the converter control
package adc_ctl_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_POWER = 3'h1;
  localparam logic [2:0] ADDR_ACCUM = 3'h2;
  localparam logic [2:0] ADDR_SARCLK = 3'h3;
  localparam logic [2:0] ADDR_TRACK = 3'h4;
  localparam logic [2:0] ADDR_RES_HI = 3'h5;
  localparam logic [2:0] ADDR_RES_LO = 3'h6;

  // Control register bits
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_BURST_BIT = 6;
  localparam int CTRL_DONE_BIT = 5;
  localparam int CTRL_START_BIT = 4;

  // Power register fields
  localparam int PWR_BUF_LP_BIT = 7;
  localparam int PWR_BIAS_HI = 6;
  localparam int PWR_BIAS_LO = 5;
  localparam int PWR_MUX_LP_BIT = 4;
  localparam int PWR_UPTIME_HI = 3;
  localparam int PWR_UPTIME_LO = 0;

  // Accumulation register fields
  localparam int ACC_RPT_HI = 2;
  localparam int ACC_RPT_LO = 0;
  localparam int ACC_JUST_HI = 5;
  localparam int ACC_JUST_LO = 3;

  // SAR clock and tracking fields
  localparam int SARCLK_DIV_HI = 7;
  localparam int SARCLK_DIV_LO = 3;
  localparam int TRACK_HI = 5;
  localparam int TRACK_LO = 0;

  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_POWER = 8'h0F;
  localparam logic [7:0] RST_ACCUM = 8'h00;
  localparam logic [7:0] RST_SARCLK = 8'hF8;
  localparam logic [7:0] RST_TRACK = 8'h1E;

  // Justify field codes
  localparam logic [2:0] JUST_RIGHT = 3'h0;
  localparam logic [2:0] JUST_LEFT = 3'h4;

  // Power-up wait is one more than the uptime field shifted left by this many bits, in SAR clocks
  localparam int UPTIME_SCALE_SH = 3;

  // Widths
  localparam int CODE_W = 10;
  localparam int ACC_W = 16;

  // Repeat count code to number of samples: 0 -> 1, 1..5 -> 4..64
  function automatic logic [6:0] repeat_total(input logic [2:0] code);
    logic [6:0] n;
    n = 7'h01;
    unique case (code)
      3'h1: n = 7'h04;
      3'h2: n = 7'h08;
      3'h3: n = 7'h10;
      3'h4: n = 7'h20;
      3'h5: n = 7'h40;
      default: n = 7'h01;
    endcase
    return n;
  endfunction

endpackage

// ===== result_formatter.sv
// Places the accumulated code into the 16-bit result word
`timescale 1ns/100ps
`default_nettype none
module result_formatter
  import adc_ctl_pkg::*;
(
  input wire logic [ACC_W-1:0] accSum,   // Accumulated or single code
  input wire logic [2:0] justify,        // result_justify_shift field
  output logic [ACC_W-1:0] resultWord    // Formatted result
);

  // ----------------------------------------------------------------
  // Justification and shift
  // ----------------------------------------------------------------
  always_comb begin
    resultWord = accSum;
    if (justify[2]) begin
      // Left form only makes sense for one sample; top code bit to bit 15
      resultWord = {accSum[CODE_W-1:0], {(ACC_W-CODE_W){1'b0}}}; // see [RQ7]
    end else begin
      // Zero shift is plain right justify; 1..3 scale the sum down
      resultWord = accSum >> justify[1:0]; // see [RQ13] see [RQ9]
    end
  end

endmodule // result_formatter
`default_nettype wire

// ===== adc_power_and_result_format.sv
// Burst power control, SAR clock, sequencing and result formatting
// Contract
// [RQ1] Burst idle powers converter and reference off
// [RQ2] Buffer low-power bit selects reduced-current buffer
// [RQ3] Bias and mux low-power fields set power
// [RQ4] Low-power options together near 4 MHz SAR
// [RQ5] Divider setting yields SAR clock from oscillator
// [RQ6] Each finished set fills both result bytes
// [RQ7] Justify 000 right, 100 left-aligned
// [RQ8] Single 10-bit result is unsigned code
// [RQ9] Unoccupied result bits read zero
// [RQ10] Sum published only after final conversion
// [RQ11] Repeat count selects 4 to 64 samples
// [RQ12] Software keeps right justify when accumulating
// [RQ13] Justify field shifts sum right 1-3
// [RQ14] Power-up wait once per burst only
// [RQ15] Burst start launches whole set of conversions
// [RQ16] Starts during running burst are dropped
// [RQ17] Accumulator cleared at each new set
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module adc_power_and_result_format
  import adc_ctl_pkg::*;
(
  input wire logic clk,                   // System clock
  input wire logic arst_n,                // Async reset, active low
  input wire logic [2:0] regAddr,         // Register index
  input wire logic [7:0] regWdata,        // Write data
  input wire logic regWe,                 // Write strobe
  input wire logic regRe,                 // Read strobe
  output logic [7:0] regRdata,            // Read data, cycle after strobe
  input wire logic extStart,              // Convert-start pin, async
  input wire logic convDone,              // SAR core finished, one pulse
  input wire logic [CODE_W-1:0] convCode, // SAR core code
  output logic convStart,                 // Starts one SAR conversion
  output logic sarClkEn,                  // SAR clock tick
  output logic convPowerOn,               // Converter core powered
  output logic refPowerOn,                // Internal reference powered
  output logic bufferLowPower,            // Common-mode buffer reduced
  output logic [1:0] coreBiasSelect,      // Core bias setting
  output logic muxBufferLowPower,         // Mux and ref buffer reduced
  output logic busy                       // Powering up, tracking or converting
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_POWERUP = 2'b01,
    ST_TRACK = 2'b10,
    ST_CONVERT = 2'b11
  } seq_state_e;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] power_q, power_d;
  logic [7:0] accum_q, accum_d;
  logic [7:0] sarclk_q, sarclk_d;
  logic [7:0] track_q, track_d;
  logic [7:0] rdata_q, rdata_d;
  logic [ACC_W-1:0] result_q, result_d;
  logic swStart;
  logic publish;
  logic [ACC_W-1:0] formatted;
  seq_state_e state_q, state_d;
  always_comb begin
    ctrl_d = ctrl_q;
    power_d = power_q;
    accum_d = accum_q;
    sarclk_d = sarclk_q;
    track_d = track_q;
    swStart = 1'b0;
    if (regWe) begin
      unique case (regAddr)
        ADDR_CTRL: begin
          ctrl_d[CTRL_ENABLE_BIT] = regWdata[CTRL_ENABLE_BIT];
          ctrl_d[CTRL_BURST_BIT] = regWdata[CTRL_BURST_BIT];
          // Writing zero clears the done flag
          if (!regWdata[CTRL_DONE_BIT]) begin
            ctrl_d[CTRL_DONE_BIT] = 1'b0;
          end
          swStart = regWdata[CTRL_START_BIT];
        end
        ADDR_POWER: power_d = regWdata; // see [RQ2] see [RQ3]
        ADDR_ACCUM: accum_d = regWdata;
        ADDR_SARCLK: sarclk_d = regWdata;
        ADDR_TRACK: track_d = regWdata;
        default: ;
      endcase
    end
    // A finishing set wins over a clear in the same cycle
    if (publish) begin
      ctrl_d[CTRL_DONE_BIT] = 1'b1;
    end
    rdata_d = 8'h00;
    if (regRe) begin
      unique case (regAddr)
        ADDR_CTRL: rdata_d = {ctrl_q[7:5], busy, 4'h0};
        ADDR_POWER: rdata_d = power_q;
        ADDR_ACCUM: rdata_d = {2'b00, accum_q[5:0]};
        ADDR_SARCLK: rdata_d = {sarclk_q[7:3], 3'h0};
        ADDR_TRACK: rdata_d = {2'b00, track_q[5:0]};
        ADDR_RES_HI: rdata_d = result_q[15:8];
        ADDR_RES_LO: rdata_d = result_q[7:0];
        default: rdata_d = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= RST_CTRL;
      power_q <= RST_POWER;
      accum_q <= RST_ACCUM;
      sarclk_q <= RST_SARCLK;
      track_q <= RST_TRACK;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      power_q <= power_d;
      accum_q <= accum_d;
      sarclk_q <= sarclk_d;
      track_q <= track_d;
      rdata_q <= rdata_d;
    end
  end
  assign regRdata = rdata_q;
  // Low-power options are plain levels to the analog side
  assign bufferLowPower = power_q[PWR_BUF_LP_BIT]; // see [RQ2]
  assign coreBiasSelect = power_q[PWR_BIAS_HI:PWR_BIAS_LO]; // see [RQ3]
  assign muxBufferLowPower = power_q[PWR_MUX_LP_BIT]; // see [RQ3]
  wire logic convEnable = ctrl_q[CTRL_ENABLE_BIT];
  wire logic burstEnable = ctrl_q[CTRL_BURST_BIT];
  wire logic [2:0] justify = accum_q[ACC_JUST_HI:ACC_JUST_LO];
  wire logic [6:0] setSize = repeat_total(accum_q[ACC_RPT_HI:ACC_RPT_LO]);
  // ----------------------------------------------------------------
  // SAR clock divider: ratio is setting plus one
  // ----------------------------------------------------------------
  logic [4:0] sarCnt_q, sarCnt_d;
  wire logic [4:0] sarDiv = sarclk_q[SARCLK_DIV_HI:SARCLK_DIV_LO];
  always_comb begin
    sarCnt_d = sarCnt_q + 5'h01;
    if (sarCnt_q >= sarDiv) begin
      sarCnt_d = 5'h00; // see [RQ5]
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sarCnt_q <= 5'h00;
    end else begin
      sarCnt_q <= sarCnt_d;
    end
  end
  assign sarClkEn = (sarCnt_q >= sarDiv); // see [RQ5]
  // ----------------------------------------------------------------
  // Start pin synchroniser and edge detect
  // ----------------------------------------------------------------
  logic [2:0] startSync_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      startSync_q <= 3'b000;
    end else begin
      startSync_q <= {startSync_q[1:0], extStart};
    end
  end
  wire logic startEvt = swStart | (startSync_q[1] & ~startSync_q[2]);
  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  logic [7:0] stepCnt_q, stepCnt_d;
  logic [6:0] convNum_q, convNum_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic convStart_q, convStart_d;
  logic [ACC_W-1:0] accNext;
  wire logic [7:0] upLimit =
    {1'b0, power_q[PWR_UPTIME_HI:PWR_UPTIME_LO], 3'b000};
  wire logic [7:0] trackLimit = {2'b00, track_q[TRACK_HI:TRACK_LO]};
  wire logic lastConv = (convNum_q + 7'h01) >= setSize;
  // Unsigned sum; single sample leaves the 10-bit code unchanged
  assign accNext = acc_q + {{(ACC_W-CODE_W){1'b0}}, convCode}; // see [RQ8]
  always_comb begin
    state_d = state_q;
    stepCnt_d = stepCnt_q;
    convNum_d = convNum_q;
    acc_d = acc_q;
    convStart_d = 1'b0;
    publish = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        // Non-burst needs the converter already enabled per start
        if (startEvt && (burstEnable || convEnable)) begin // see [RQ15]
          stepCnt_d = 8'h00;
          if (convNum_q == 7'h00) begin
            acc_d = '0; // see [RQ17]
          end
          if (burstEnable && !convEnable) begin
            state_d = ST_POWERUP;
          end else begin
            state_d = ST_TRACK;
          end
        end
      end
      ST_POWERUP: begin
        if (sarClkEn) begin
          stepCnt_d = stepCnt_q + 8'h01;
          if (stepCnt_q >= upLimit) begin
            stepCnt_d = 8'h00;
            state_d = ST_TRACK;
          end
        end
      end
      ST_TRACK: begin
        if (sarClkEn) begin
          stepCnt_d = stepCnt_q + 8'h01;
          if (stepCnt_q >= trackLimit) begin
            stepCnt_d = 8'h00;
            convStart_d = 1'b1;
            state_d = ST_CONVERT;
          end
        end
      end
      ST_CONVERT: begin
        if (convDone) begin
          acc_d = accNext;
          convNum_d = convNum_q + 7'h01;
          state_d = ST_IDLE;
          if (lastConv) begin
            convNum_d = 7'h00;
            publish = 1'b1; // see [RQ10] see [RQ11]
          end else if (burstEnable) begin
            // Later conversions of a burst skip the power-up wait
            state_d = ST_TRACK; // see [RQ14] see [RQ15]
          end
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      stepCnt_q <= 8'h00;
      convNum_q <= 7'h00;
      acc_q <= '0;
      convStart_q <= 1'b0;
    end else begin
      state_q <= state_d;
      stepCnt_q <= stepCnt_d;
      convNum_q <= convNum_d;
      acc_q <= acc_d;
      convStart_q <= convStart_d;
    end
  end
  assign convStart = convStart_q;
  // Starts seen outside ST_IDLE are simply not looked at
  assign busy = (state_q != ST_IDLE); // see [RQ16]
  // Burst idle drops power unless the enable keeps it on
  assign convPowerOn = burstEnable ? (convEnable | busy) : convEnable; // see [RQ1]
  assign refPowerOn = convPowerOn; // see [RQ1]

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  result_formatter u_fmt (
    .accSum(accNext),
    .justify(justify),
    .resultWord(formatted)
  );

  always_comb begin
    result_d = result_q;
    if (publish) begin
      result_d = formatted; // see [RQ6]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= '0;
    end else begin
      result_q <= result_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_powerWrite;
    regWe && regAddr == ADDR_POWER;
  endsequence
  sequence s_setDone;
    state_q == ST_CONVERT && convDone && lastConv;
  endsequence
  a_burst_idle_off: assert property ( // see [RQ1]
    @(posedge clk) disable iff (!arst_n)
    burstEnable && !convEnable && state_q == ST_IDLE |-> !convPowerOn && !refPowerOn)
    else $error("converter powered while burst idle");
  a_buf_lp_follow: assert property ( // see [RQ2]
    @(posedge clk) disable iff (!arst_n)
    s_powerWrite |=> bufferLowPower == $past(regWdata[PWR_BUF_LP_BIT]))
    else $error("buffer low-power bit not applied");
  a_bias_mux_follow: assert property ( // see [RQ3]
    @(posedge clk) disable iff (!arst_n)
    s_powerWrite |=> coreBiasSelect == $past(regWdata[PWR_BIAS_HI:PWR_BIAS_LO])
      && muxBufferLowPower == $past(regWdata[PWR_MUX_LP_BIT]))
    else $error("bias or mux field not applied");
  // Tick must alternate whenever the divider stayed at one across the edge
  a_sar_div_one: assert property ( // see [RQ5]
    @(posedge clk) disable iff (!arst_n)
    sarDiv == 5'h01 && $stable(sarDiv)
      |-> sarClkEn != $past(sarClkEn))
    else $error("SAR tick not every second clock");
  a_result_load: assert property ( // see [RQ6]
    @(posedge clk) disable iff (!arst_n)
    s_setDone |=> result_q == $past(formatted) && ctrl_q[CTRL_DONE_BIT])
    else $error("result not loaded at set end");
  a_left_justify: assert property ( // see [RQ7]
    @(posedge clk) disable iff (!arst_n)
    s_setDone and (justify == JUST_LEFT)
      |=> result_q[5:0] == 6'h00 && result_q[15:6] == $past(accNext[9:0]))
    else $error("left justify placement wrong");
  a_right_zero: assert property ( // see [RQ9]
    @(posedge clk) disable iff (!arst_n)
    s_setDone and (justify == JUST_RIGHT && setSize == 7'h01)
      |=> result_q[15:10] == 6'h00)
    else $error("unused result bits not zero");
  a_result_hold: assert property ( // see [RQ10]
    @(posedge clk) disable iff (!arst_n)
    !publish |=> $stable(result_q))
    else $error("result changed mid set");
  a_powerup_once: assert property ( // see [RQ14]
    @(posedge clk) disable iff (!arst_n)
    state_q == ST_CONVERT |=> state_q != ST_POWERUP)
    else $error("power-up wait repeated inside burst");
  a_acc_cleared: assert property ( // see [RQ17]
    @(posedge clk) disable iff (!arst_n)
    state_q == ST_IDLE && state_d != ST_IDLE && convNum_q == 7'h00
      |=> acc_q == '0)
    else $error("accumulator not cleared at set start");
endmodule // adc_power_and_result_format
`default_nettype wire

// ===== sar_core_model.sv
// Behavioural SAR core that answers the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module sar_core_model
  import adc_ctl_pkg::*;
#(
  parameter int LAT = 5                 // Clocks from start to done
) (
  input wire logic clk,                 // System clock
  input wire logic arst_n,              // Async reset, active low
  input wire logic convStart,           // Start one conversion
  input wire logic convPowerOn,         // Core power from the block
  input wire logic [CODE_W-1:0] codeIn, // Code to hand back
  output logic convDone,                // One-cycle done pulse
  output logic [CODE_W-1:0] convCode    // Code, valid with done only
);
  int cnt;
  logic powered;
  logic [CODE_W-1:0] lastCode;

  // An unpowered core hands back a corrupted code, so a missing power-up
  // shows in the result; between answers the code lines do not hold
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      powered <= 1'b0;
      lastCode <= '0;
      convDone <= 1'b0;
      convCode <= '0;
    end else begin
      convDone <= 1'b0;
      convCode <= ~lastCode;
      if (convStart) begin
        cnt <= LAT;
        powered <= convPowerOn;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          convDone <= 1'b1;
          convCode <= powered ? codeIn : ~codeIn;
          lastCode <= powered ? codeIn : ~codeIn;
        end
      end
    end
  end
endmodule // sar_core_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for converter power control and result format
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import adc_ctl_pkg::*;
;
  localparam int LIMIT = 20000;
  localparam logic [9:0] SCODE [4] = '{10'h3FF, 10'h000, 10'h200, 10'h100};
  localparam logic [9:0] BCODE [5] = '{10'h3FF, 10'h200, 10'h1FF, 10'h3FF,
                                       10'h155};
  logic clk, arst_n, regWe, regRe, extStart;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic convDone, convStart, sarClkEn, convPowerOn, refPowerOn, busy;
  logic bufferLowPower, muxBufferLowPower;
  logic [1:0] coreBiasSelect;
  logic [CODE_W-1:0] convCode, codeIn;
  int n_errors, n_compared, cycles, startCount;

  adc_power_and_result_format adc_power_and_result_format_inst (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWe(regWe), .regRe(regRe), .regRdata(regRdata),
    .extStart(extStart), .convDone(convDone), .convCode(convCode),
    .convStart(convStart), .sarClkEn(sarClkEn), .convPowerOn(convPowerOn),
    .refPowerOn(refPowerOn), .bufferLowPower(bufferLowPower),
    .coreBiasSelect(coreBiasSelect), .muxBufferLowPower(muxBufferLowPower),
    .busy(busy));
  sar_core_model sar_core_model_inst (
    .clk(clk), .arst_n(arst_n), .convStart(convStart),
    .convPowerOn(convPowerOn), .codeIn(codeIn), .convDone(convDone),
    .convCode(convCode));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (convStart === 1'b1) startCount++;
    if (cycles == LIMIT) begin
      n_errors++;
      summarize();
    end
  end

  // ---------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------
  task automatic check(input string w, input logic [15:0] s,
                       input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWe <= 1'b1;
    @(posedge clk);
    regWe <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRe <= 1'b1;
    @(posedge clk);
    regRe <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic rdChk(input logic [2:0] a, input logic [7:0] e,
                       input string w);
    logic [7:0] d;
    rd(a, d);
    check(w, {8'h00, d}, {8'h00, e});
  endtask

  task automatic rdRes(output logic [15:0] r);
    logic [7:0] h;
    logic [7:0] l;
    rd(ADDR_RES_HI, h);
    rd(ADDR_RES_LO, l);
    r = {h, l};
  endtask

  // Bounded so a stuck sequencer cannot hang the run
  task automatic waitIdle();
    int n;
    n = 0;
    repeat (6) @(posedge clk);
    #1;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("idle wait", 16'(n >= 2000), 16'h0000);
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_reset();
    rdChk(ADDR_CTRL, RST_CTRL, "ctrl reset");
    rdChk(ADDR_POWER, RST_POWER, "power reset");
    rdChk(ADDR_ACCUM, RST_ACCUM, "accum reset");
    rdChk(ADDR_SARCLK, RST_SARCLK, "sarclk reset");
    rdChk(ADDR_TRACK, RST_TRACK, "track reset");
    rdChk(3'h7, 8'h00, "unmapped read");
    $display("test reset done");
  endtask

  task automatic t_power();
    logic [7:0] v [4] = '{8'hF4, 8'h40, 8'h80, 8'h10};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_POWER, v[i]);
      @(posedge clk);
      #1;
      check("buffer lp", 16'(bufferLowPower), 16'(v[i][7]));
      check("core bias", 16'(coreBiasSelect), 16'(v[i][6:5]));
      check("mux lp", 16'(muxBufferLowPower), 16'(v[i][4]));
      rdChk(ADDR_POWER, v[i], "power readback");
    end
    $display("test power done");
  endtask

  task automatic t_sarclk();
    int n;
    for (int d = 1; d <= 5; d += 4) begin
      wr(ADDR_SARCLK, {d[4:0], 3'h0});
      repeat (40) @(posedge clk);
      n = 0;
      repeat (60) begin
        @(posedge clk);
        #1;
        if (sarClkEn === 1'b1) n++;
      end
      check("sar ticks", 16'(n), 16'(60 / (d + 1)));
    end
    $display("test sarclk done");
  endtask

  task automatic t_single();
    logic [15:0] r;
    logic [15:0] e;
    wr(ADDR_POWER, 8'h00);
    wr(ADDR_SARCLK, 8'h08);
    wr(ADDR_TRACK, 8'h00);
    // Enable must already stand when the first start strobe is seen
    wr(ADDR_CTRL, 8'h80);
    for (int j = 0; j < 8; j++) begin
      wr(ADDR_ACCUM, (j < 4) ? 8'h00 : {2'b00, JUST_LEFT, 3'h0});
      codeIn = SCODE[j % 4];
      wr(ADDR_CTRL, 8'h90);
      waitIdle();
      rdRes(r);
      e = (j < 4) ? {6'h00, SCODE[j % 4]} : {SCODE[j % 4], 6'h00};
      check("single result", r, e);
    end
    rdChk(ADDR_CTRL, 8'hA0, "done flag");
    $display("test single done");
  endtask

  // Partial sums must never reach the result bytes
  task automatic t_accum();
    logic [15:0] r;
    wr(ADDR_ACCUM, 8'h01);
    codeIn = 10'h3FF;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, 8'h90);
      waitIdle();
      if (k == 2) begin
        rdRes(r);
        check("partial set", r, 16'h4000);
        rdChk(ADDR_CTRL, 8'h80, "done early");
      end
    end
    rdRes(r);
    check("sum of four", r, 16'h0FFC);
    $display("test accum done");
  endtask

  task automatic t_burst();
    logic [15:0] r;
    int n;
    int sh;
    for (int k = 1; k <= 5; k++) begin
      n = 4 << (k - 1);
      sh = (k - 1) % 4;
      wr(ADDR_ACCUM, {2'b00, sh[2:0], k[2:0]});
      codeIn = BCODE[k - 1];
      startCount = 0;
      if (k == 5) begin
        @(posedge clk);
        extStart <= 1'b1;
        repeat (4) @(posedge clk);
        extStart <= 1'b0;
      end else begin
        wr(ADDR_CTRL, 8'h50);
      end
      waitIdle();
      rdRes(r);
      check("burst sum", r, 16'((n * BCODE[k-1]) >> sh));
      check("burst starts", 16'(startCount), 16'(n));
    end
    $display("test burst done");
  endtask

  task automatic t_burst_power();
    logic [15:0] r;
    int first, gap, maxGap, bad;
    wr(ADDR_POWER, 8'h02);
    wr(ADDR_ACCUM, 8'h01);
    wr(ADDR_CTRL, 8'h40);
    codeIn = 10'h200;
    repeat (4) @(posedge clk);
    #1;
    check("idle power", 16'({convPowerOn, refPowerOn}), 16'h0);
    startCount = 0;
    first = 0;
    gap = 0;
    maxGap = 0;
    bad = 0;
    fork
      begin
        wr(ADDR_CTRL, 8'h50);
        repeat (20) @(posedge clk);
        wr(ADDR_CTRL, 8'h50);
      end
      for (int i = 0; i < 400; i++) begin
        @(posedge clk);
        #1;
        if (busy === 1'b1 && {convPowerOn, refPowerOn} !== 2'b11) bad++;
        if (convDone === 1'b1) gap = 0;
        else gap++;
        if (convStart === 1'b1 && first == 0) first = i;
        else if (convStart === 1'b1 && gap > maxGap) maxGap = gap;
      end
    join
    // Wait is 17 SAR ticks of 2 clocks each
    check("power-up wait", 16'(first >= 34), 16'h0001);
    check("no wait inside", 16'(maxGap < 34), 16'h0001);
    check("power in burst", 16'(bad), 16'h0000);
    check("late start", 16'(startCount), 16'h0004);
    check("off after", 16'({convPowerOn, refPowerOn}), 16'h0);
    rdRes(r);
    check("burst power sum", r, 16'h0800);
    $display("test burst power done");
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    regAddr = 3'h0;
    regWdata = 8'h00;
    regWe = 1'b0;
    regRe = 1'b0;
    extStart = 1'b0;
    codeIn = '0;
    arst_n = 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_power();
    t_sarclk();
    t_single();
    t_accum();
    t_burst();
    t_burst_power();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
